// File: hdl/pcpo_pkg.sv
// package: constants and types for the position compare pulse output block
package pcpo_pkg;
    localparam int unsigned PCPO_CLK_HZ = 25_000_000;
    localparam int unsigned PCPO_CLK_NS = 40;
    // fixed trigger-bus pulse length, in ns
    localparam int unsigned PCPO_TRIG_PULSE_NS = 200;
    // longest time rounds down, never below one cycle
    localparam int unsigned PCPO_TRIG_CYC_RAW = PCPO_TRIG_PULSE_NS / PCPO_CLK_NS;
    localparam int unsigned PCPO_TRIG_CYC = (PCPO_TRIG_CYC_RAW < 1) ? 1 : PCPO_TRIG_CYC_RAW;
    // only the primary encoder index is accepted
    localparam logic [3:0] PCPO_ENC_PRIMARY = 4'h1;
    localparam int unsigned PCPO_POS_W = 32;
    localparam int unsigned PCPO_WIDTH_W = 16;
    localparam int unsigned PCPO_AXES = 4;
    localparam logic [15:0] PCPO_WIDTH_RST = 16'h0001;
    typedef enum logic [1:0] {
        PCPO_IDLE,
        PCPO_ARMED,
        PCPO_FAULT
    } pcpo_state_t;
endpackage : pcpo_pkg

// File: hdl/pcpo_pulse.sv
// one-shot pulse stretcher with overlap detection
`timescale 1ns/10ps
module pcpo_pulse #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic fire_i,
    input wire logic [CNT_W-1:0] len_i,
    input wire logic kill_i,
    // status
    output logic active_o,
    output logic overlap_o
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    wire logic busy = (cnt_r != '0);
    wire logic [CNT_W-1:0] len_min1 = (len_i == '0) ? CNT_W'(1) : len_i;

    assign cnt_nxt = kill_i ? '0 : (fire_i && !busy) ? len_min1 : busy ? cnt_r - CNT_W'(1) : cnt_r;
    assign active_o = busy;
    assign overlap_o = fire_i && busy;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : pcpo_pulse

// File: hdl/pcpo_top.sv
// per-axis position compare pulse generator
`timescale 1ns/10ps
module pcpo_top
    import pcpo_pkg::*;
#(
    parameter int unsigned AXES = pcpo_pkg::PCPO_AXES,
    parameter int unsigned POS_W = pcpo_pkg::PCPO_POS_W,
    parameter int unsigned WIDTH_W = pcpo_pkg::PCPO_WIDTH_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration write, one axis at a time
    input wire logic cfg_we_i,
    input wire logic [$clog2(AXES)-1:0] cfg_axis_i,
    input wire logic [3:0] cfg_enc_i,
    input wire logic [WIDTH_W-1:0] cfg_width_i,
    input wire logic [POS_W-1:0] cfg_point_i,
    input wire logic cfg_enable_i,
    input wire logic cfg_trig_route_i,
    // primary encoder positions, flattened per axis
    input wire logic [AXES*POS_W-1:0] enc_pos_i,
    // outputs
    output logic [AXES-1:0] cmp_out_o,
    output logic [AXES-1:0] system_trigger_bus_o,
    output logic [AXES-1:0] cmp_armed_o,
    output logic [AXES-1:0] overlap_err_o,
    output logic cfg_reject_o
);
    import pcpo_pkg::*;

    localparam int unsigned AXIS_W = $clog2(AXES);
    localparam logic [WIDTH_W-1:0] TRIG_LEN = WIDTH_W'(PCPO_TRIG_CYC);

    // only a write naming the primary encoder is taken
    wire logic cfg_ok = cfg_we_i && (cfg_enc_i == PCPO_ENC_PRIMARY);
    wire logic reject_nxt = cfg_we_i && !cfg_ok;
    logic reject_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reject_r <= 1'b0;
        end else begin
            reject_r <= reject_nxt;
        end
    end
    assign cfg_reject_o = reject_r;

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            localparam logic [AXIS_W-1:0] AXIS_ID = AXIS_W'(g);

            // stored configuration of this axis
            logic [WIDTH_W-1:0] width_r;
            logic [WIDTH_W-1:0] width_nxt;
            logic [POS_W-1:0] point_r;
            logic [POS_W-1:0] point_nxt;
            logic route_r;
            logic route_nxt;
            // control state and status
            pcpo_state_t state_r;
            pcpo_state_t state_nxt;
            logic fault_r;
            logic fault_nxt;
            logic hit_r;
            logic hit_nxt;
            logic armed_r;
            logic armed_nxt;
            logic out_r;
            logic out_nxt;
            logic trig_r;
            logic trig_nxt;
            // pulse stretcher status
            logic busy;
            logic ovl;
            logic tbusy;

            wire logic [POS_W-1:0] pos = enc_pos_i[g*POS_W +: POS_W];
            wire logic wr = cfg_ok && (cfg_axis_i == AXIS_ID);
            wire logic reached = (pos == point_r);
            // one event per arrival at the compare point
            wire logic event_p = (state_r == PCPO_ARMED) && reached && !hit_r;
            // both stretchers are cleared whenever the axis is not armed
            wire logic kill = (state_r != PCPO_ARMED);
            wire logic fire_cmp = event_p && !route_r;
            wire logic fire_trig = event_p && route_r;
            wire logic overlap = ovl;

            // configured width; a width of 0 is stretched to one cycle
            pcpo_pulse #(.CNT_W(WIDTH_W)) u_pulse (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .fire_i(fire_cmp),
                .len_i(width_r),
                .kill_i(kill),
                .active_o(busy),
                .overlap_o(ovl)
            );
            // fixed length; an event inside a running trigger pulse is ignored
            pcpo_pulse #(.CNT_W(WIDTH_W)) u_trig (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .fire_i(fire_trig),
                .len_i(TRIG_LEN),
                .kill_i(kill),
                .active_o(tbusy),
                .overlap_o()
            );

            always_comb begin
                state_nxt = state_r;
                case (state_r)
                    PCPO_IDLE: begin
                        if (wr && cfg_enable_i) begin
                            state_nxt = PCPO_ARMED;
                        end
                    end
                    PCPO_ARMED: begin
                        // an overlap outranks a write landing in the same cycle
                        if (overlap) begin
                            state_nxt = PCPO_FAULT;
                        end else if (wr) begin
                            state_nxt = cfg_enable_i ? PCPO_ARMED : PCPO_IDLE;
                        end
                    end
                    PCPO_FAULT: begin
                        if (wr) begin
                            state_nxt = cfg_enable_i ? PCPO_ARMED : PCPO_IDLE;
                        end
                    end
                    default: begin
                        state_nxt = PCPO_IDLE;
                    end
                endcase
            end

            assign width_nxt = wr ? cfg_width_i : width_r;
            assign point_nxt = wr ? cfg_point_i : point_r;
            assign route_nxt = wr ? cfg_trig_route_i : route_r;
            assign hit_nxt = reached;
            // a fault raised in the same cycle as a clearing write is kept
            assign fault_nxt = ((state_r == PCPO_ARMED) && overlap) || (fault_r && !wr);
            assign armed_nxt = (state_nxt == PCPO_ARMED);
            // the output drops in the cycle after the overlap is seen, together with the fault flag
            assign out_nxt = busy && armed_nxt;
            assign trig_nxt = tbusy && armed_nxt;

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    width_r <= WIDTH_W'(PCPO_WIDTH_RST);
                    point_r <= '0;
                    route_r <= 1'b0;
                end else begin
                    width_r <= width_nxt;
                    point_r <= point_nxt;
                    route_r <= route_nxt;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    state_r <= PCPO_IDLE;
                end else begin
                    state_r <= state_nxt;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    fault_r <= 1'b0;
                end else begin
                    fault_r <= fault_nxt;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    hit_r <= 1'b0;
                end else begin
                    hit_r <= hit_nxt;
                end
            end

            // armed level kept in its own flop so the output is registered
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    armed_r <= 1'b0;
                end else begin
                    armed_r <= armed_nxt;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    out_r <= 1'b0;
                end else begin
                    out_r <= out_nxt;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    trig_r <= 1'b0;
                end else begin
                    trig_r <= trig_nxt;
                end
            end

            assign cmp_out_o[g] = out_r;
            assign system_trigger_bus_o[g] = trig_r;
            assign cmp_armed_o[g] = armed_r;
            assign overlap_err_o[g] = fault_r;
        end
    endgenerate
endmodule : pcpo_top

// File: tb/pcpo_asserts.sv
// checker: compare pulse timing for axis 0, trigger pulse timing for the last axis
`timescale 1ns/10ps
module pcpo_asserts #(
    parameter int unsigned AXES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cfg_we_i,
    input wire logic [$clog2(AXES)-1:0] cfg_axis_i,
    input wire logic [3:0] cfg_enc_i,
    input wire logic cfg_enable_i,
    input wire logic [AXES-1:0] cmp_out_o,
    input wire logic [AXES-1:0] system_trigger_bus_o,
    input wire logic [AXES-1:0] cmp_armed_o,
    input wire logic [AXES-1:0] overlap_err_o,
    input wire logic cfg_reject_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire ok_w = cfg_we_i && cfg_enc_i == 4'h1 && cfg_axis_i == '0;
    a_bad_index: assert property (cfg_we_i && cfg_enc_i != 4'h1 |=> cfg_reject_o)
        else $error("reject missing");
    a_reject_cause: assert property (cfg_reject_o |-> $past(cfg_we_i && cfg_enc_i != 4'h1))
        else $error("reject without cause");
    a_arm_write: assert property (ok_w && cfg_enable_i |=> cmp_armed_o[0] || overlap_err_o[0])
        else $error("axis not armed");
    a_trig_len: assert property ($rose(system_trigger_bus_o[AXES-1]) |-> system_trigger_bus_o[AXES-1] [*5]
        ##1 !system_trigger_bus_o[AXES-1])
        else $error("trigger pulse length");
    a_fault_off: assert property ($rose(overlap_err_o[0]) |-> !cmp_out_o[0] && !cmp_armed_o[0])
        else $error("output live in fault");
    a_err_hold: assert property (overlap_err_o[0] && !ok_w |=> overlap_err_o[0])
        else $error("fault flag lost");
    a_err_clear: assert property (overlap_err_o[0] && ok_w |=> !overlap_err_o[0])
        else $error("fault flag stuck");
    a_out_armed: assert property ($rose(cmp_out_o[0]) |-> $past(cmp_armed_o[0], 2))
        else $error("pulse while idle");
endmodule : pcpo_asserts
bind pcpo_top pcpo_asserts #(.AXES(AXES)) pcpo_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .cfg_we_i(cfg_we_i), .cfg_axis_i(cfg_axis_i), .cfg_enc_i(cfg_enc_i), .cfg_enable_i(cfg_enable_i),
    .cmp_out_o(cmp_out_o), .system_trigger_bus_o(system_trigger_bus_o), .cmp_armed_o(cmp_armed_o),
    .overlap_err_o(overlap_err_o), .cfg_reject_o(cfg_reject_o));

// File: tb/pcpo_partner.sv
// triggered device: measures each pulse length per line
`timescale 1ns/10ps
module pcpo_partner (
    input wire logic clk_i,
    input wire logic [3:0] line_i,
    output logic [3:0][7:0] len_o
);
    logic [3:0][7:0] run_r;
    always_ff @(posedge clk_i) begin
        for (int g = 0; g < 4; g++) begin
            run_r[g] <= line_i[g] ? run_r[g] + 8'h01 : 8'h00;
            if (!line_i[g] && run_r[g] != 8'h00) len_o[g] <= run_r[g];
        end
    end
endmodule : pcpo_partner

// File: tb/pcpo_top_bench.sv
// testbench: width, index check, trigger route and overlap fault
`timescale 1ns/10ps
module pcpo_top_bench;
    logic clk_i = 0, rst_i = 1, cfg_we_i = 0, cfg_enable_i = 1, cfg_trig_route_i = 0, reject_o;
    logic [1:0] cfg_axis_i = 0;
    logic [3:0] cfg_enc_i = 0;
    logic [15:0] cfg_width_i = 0;
    logic [31:0] cfg_point_i = 32'h0000_0064;
    logic [127:0] enc_pos_i = 0;
    logic [3:0] cmp_out_o, trig_o, armed_o, err_o;
    logic [3:0][7:0] out_len, trig_len;
    int fail_count = 0, n_tests = 0;
    always #20 clk_i = ~clk_i;
    pcpo_top pcpo_top_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_we_i(cfg_we_i), .cfg_axis_i(cfg_axis_i),
        .cfg_enc_i(cfg_enc_i), .cfg_width_i(cfg_width_i), .cfg_point_i(cfg_point_i), .cfg_enable_i(cfg_enable_i),
        .cfg_trig_route_i(cfg_trig_route_i), .enc_pos_i(enc_pos_i), .cmp_out_o(cmp_out_o),
        .system_trigger_bus_o(trig_o), .cmp_armed_o(armed_o), .overlap_err_o(err_o), .cfg_reject_o(reject_o));
    pcpo_partner pcpo_partner_i (.clk_i(clk_i), .line_i(cmp_out_o), .len_o(out_len));
    pcpo_partner pcpo_trig_partner_i (.clk_i(clk_i), .line_i(trig_o), .len_o(trig_len));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [3:0] e, input logic [15:0] w, input logic r);
        cfg_axis_i = a;
        cfg_enc_i = e;
        cfg_width_i = w;
        cfg_trig_route_i = r;
        cfg_we_i = 1;
        cyc(1);
        cfg_we_i = 0;
    endtask : wr
    task automatic hit(input logic [3:0] m);
        for (int g = 0; g < 4; g++) enc_pos_i[g*32 +: 32] = m[g] ? cfg_point_i : 32'h0000_0000;
        cyc(1);
        enc_pos_i = 0;
    endtask : hit
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (400) @(posedge clk_i);
        fail_count++;
        stop_test;
    end
    initial begin
        cyc(20);
        rst_i = 0;
        cyc(1);
        wr(0, 1, 16'h0003, 0);
        cyc(1);
        wr(1, 1, 16'h0006, 0);
        cyc(2);
        hit(4'h3);
        cyc(12);
        chk("width axis0", 16'h0003, out_len[0]);
        chk("width axis1", 16'h0006, out_len[1]);
        $display("width test done");
        wr(2, 2, 16'h0003, 0);
        chk("reject", 16'h0001, reject_o);
        chk("armed axis2", 16'h0000, armed_o[2]);
        $display("index test done");
        cyc(1);
        wr(3, 1, 16'h0009, 1);
        cyc(2);
        hit(4'h8);
        cyc(10);
        chk("trigger length", 16'h0005, trig_len[3]);
        $display("trigger test done");
        wr(0, 1, 16'h000a, 0);
        cyc(2);
        hit(4'h1);
        cyc(4);
        hit(4'h1);
        cyc(4);
        chk("overlap flag", 16'h0001, err_o[0]);
        chk("armed after fault", 16'h0000, armed_o[0]);
        chk("output after fault", 16'h0000, cmp_out_o[0]);
        chk("cut pulse", 16'h0004, out_len[0]);
        wr(0, 1, 16'h0002, 0);
        chk("flag after rewrite", 16'h0000, err_o[0]);
        chk("armed after rewrite", 16'h0001, armed_o[0]);
        cyc(2);
        hit(4'h1);
        cyc(6);
        chk("width after rewrite", 16'h0002, out_len[0]);
        $display("overlap test done");
        cfg_enable_i = 0;
        wr(1, 1, 16'h0004, 0);
        chk("armed disabled", 16'h0000, armed_o[1]);
        cyc(2);
        hit(4'h2);
        cyc(8);
        chk("no pulse disabled", 16'h0006, out_len[1]);
        cfg_enable_i = 1;
        $display("disable test done");
        stop_test;
    end
endmodule : pcpo_top_bench
